/* File: design/atc_pkg.sv */
// Package for the 8-bit timer with one compare unit: offsets, fields, codes.
// Assumes a 32-bit AHB-Lite register bus with one word per register.
package atc_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] ATC_OFS_CONTROL = 8'h00;
  localparam logic [7:0] ATC_OFS_COUNT   = 8'h04;
  localparam logic [7:0] ATC_OFS_COMPARE = 8'h08;
  localparam logic [7:0] ATC_OFS_FLAGS   = 8'h0c;
  localparam logic [7:0] ATC_OFS_MASK    = 8'h10;
  localparam logic [7:0] ATC_OFS_ASYNC   = 8'h14;

  // ==========================================================================
  // Field positions
  localparam int ATC_FLD_FORCE   = 7;  // Force strobe, reads zero
  localparam int ATC_FLD_OVF     = 0;  // Overflow bit in flag and mask
  localparam int ATC_FLD_CMP     = 1;  // Compare bit in flag and mask
  localparam int ATC_FLD_ASYNC   = 0;  // Crystal clock select

  // ==========================================================================
  // Counter limits and reset values
  localparam logic [7:0] ATC_BOTTOM     = 8'h00;
  localparam logic [7:0] ATC_MAX        = 8'hff;
  localparam logic [7:0] ATC_RST_BYTE   = 8'h00;
  localparam logic [9:0] ATC_PRESC_ZERO = 10'h000;

  // Prescaler divide masks for clock select 1..7 (divide by 1,8,32,64,128,256,1024)
  localparam logic [9:0] ATC_DIV_MASK [1:7] = '{10'h000, 10'h007, 10'h01f, 10'h03f,
                                                 10'h07f, 10'h0ff, 10'h3ff};

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    ATC_MODE_NORMAL = 2'h0,
    ATC_MODE_PHASE  = 2'h1,
    ATC_MODE_CTC    = 2'h2,
    ATC_MODE_FAST   = 2'h3
  } atc_mode_t;

  // Timer control register layout
  typedef struct packed {
    logic       force_compare_strobe;
    logic [1:0] compare_output_mode;
    atc_mode_t  wave_mode_field;
    logic [2:0] clock_select_field;
  } atc_ctrl_t;

  // Two flags or two enables
  typedef struct packed {
    logic compare;
    logic overflow;
  } atc_pair_t;

  typedef enum logic [2:0] {
    ATC_BUS_IDLE  = 3'b001,
    ATC_BUS_RWAIT = 3'b010,
    ATC_BUS_RDONE = 3'b100
  } atc_bus_t;

  localparam atc_ctrl_t ATC_RST_CTRL = '0;

endpackage : atc_pkg

/* File: design/atc_timer.sv */
// 8-bit timer/counter with one compare unit behind an AHB-Lite slave.
// Assumes the crystal pin is already synchronous to hclk; one clock domain.
//
// Summary of operation
// (RQ1) Eight-bit counter, bottom 0x00, max 0xff.
// (RQ2) Top is max or compare value, by mode.
// (RQ3) Async select picks crystal pin over io clock.
// (RQ4) Clock select zero stops the counter.
// (RQ5) Counter readable and writable while stopped.
// (RQ6) Counter write beats clear and count.
// (RQ7) Each tick clears, increments or decrements by mode.
// (RQ8) Overflow flag set where mode says.
// (RQ9) Match sets compare flag on next tick.
// (RQ10) Enabled compare flag interrupts; ack or W1C clears.
// (RQ11) PWM modes double buffer compare value.
// (RQ12) Writes reach buffer in PWM, else active.
// (RQ13) Force strobe acts on output only, non-PWM.
// (RQ14) Counter write blocks match on next tick.
// (RQ15) Output driven from match, mode and output mode.
// (RQ16) Output state kept across mode changes.
// (RQ17) Output mode changes take effect at once.
// (RQ18) Software presets output before enabling pin.
// (RQ19) Software avoids writing count equal to compare.
// (RQ20) Each request flagged and individually masked.
// (RQ21) Normal mode counts up, overflow on wrap.
// (RQ22) Clear-on-match mode clears at compare value.
// (RQ23) Output mode zero leaves output untouched.
// (RQ24) Hardware set beats software clear.
`timescale 1ns/1ps
module atc_timer
  import atc_pkg::*;
#(
  parameter int PRESC_BITS = 10
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        crystal_pin_in,
  input  wire logic        ack_overflow,
  input  wire logic        ack_compare,
  output logic             irq_overflow,
  output logic             irq_compare,
  output logic             compare_output,
  output logic             compare_output_override
);

  // ==========================================================================
  // Elaboration check: taps reach bit 9
  if (PRESC_BITS != 10) begin : g_bad_presc
    $error("atc_timer: PRESC_BITS must be 10");
  end

  // ==========================================================================
  // State
  atc_ctrl_t  timer_control_register;
  atc_pair_t  timer_flag_register;
  atc_pair_t  timer_mask_register;
  logic       async_clock_select;
  logic [7:0] count_value;
  logic [7:0] compare_value;
  logic [7:0] compare_buffer;
  logic       count_down;
  logic       block_match;
  logic       crystal_prev;
  logic [PRESC_BITS-1:0] presc;
  atc_bus_t   bus_state;
  logic       wr_pend;
  logic [7:0] wr_addr;
  logic [7:0] rd_addr;

  // ==========================================================================
  // Bus decode
  wire        addr_take = hsel & htrans[1] & hready;
  wire        wr_ctrl   = wr_pend & (wr_addr == ATC_OFS_CONTROL);
  wire        wr_count  = wr_pend & (wr_addr == ATC_OFS_COUNT);
  wire        wr_cmp    = wr_pend & (wr_addr == ATC_OFS_COMPARE);
  wire        wr_flags  = wr_pend & (wr_addr == ATC_OFS_FLAGS);
  wire        wr_mask   = wr_pend & (wr_addr == ATC_OFS_MASK);
  wire        wr_async  = wr_pend & (wr_addr == ATC_OFS_ASYNC);

  // Zero-wait writes; reads take one wait state so data come from a flop
  assign hreadyout = (bus_state != ATC_BUS_RWAIT);
  assign hresp     = 1'b0;

  // ==========================================================================
  // Clock select and prescaler
  atc_mode_t  mode;
  logic [2:0] csel;
  assign mode = timer_control_register.wave_mode_field;
  assign csel = timer_control_register.clock_select_field;

  wire src_tick = async_clock_select ? (crystal_pin_in & ~crystal_prev) : 1'b1; // [RQ3]
  wire [PRESC_BITS-1:0] div_mask = (csel == 3'h0) ? ATC_PRESC_ZERO : ATC_DIV_MASK[csel];
  wire timer_tick = (csel != 3'h0) & src_tick & ((presc & div_mask) == div_mask); // [RQ4]

  // ==========================================================================
  // Counter decode
  wire pwm_mode   = (mode == ATC_MODE_PHASE) | (mode == ATC_MODE_FAST);
  wire match      = (count_value == compare_value);                  // [RQ9]
  wire at_max     = (count_value == ATC_MAX);                        // [RQ1]
  wire at_bottom  = (count_value == ATC_BOTTOM);
  wire [7:0] top  = (mode == ATC_MODE_CTC) ? compare_value : ATC_MAX; // [RQ2]
  wire at_top     = (count_value == top);
  wire hit        = timer_tick & match & ~block_match;               // [RQ14]
  wire force_now  = wr_ctrl & hwdata[ATC_FLD_FORCE] & ~pwm_mode;     // [RQ13]

  // Next count per waveform mode
  logic [7:0] next_count;
  logic       next_down;
  logic       ovf_set;
  logic       buf_load;
  always_comb begin
    next_count = count_value;
    next_down  = count_down;
    ovf_set    = 1'b0;
    buf_load   = 1'b0;
    if (timer_tick) begin
      unique case (mode)
        ATC_MODE_NORMAL: begin
          next_count = count_value + 8'h01;                          // [RQ21]
          ovf_set    = at_max;
        end
        ATC_MODE_CTC: begin
          next_count = at_top ? ATC_BOTTOM : count_value + 8'h01;    // [RQ22]
          ovf_set    = at_max;
        end
        ATC_MODE_FAST: begin
          next_count = count_value + 8'h01;                          // [RQ7]
          ovf_set    = at_max;                                       // [RQ8]
          buf_load   = at_max;                                       // [RQ11]
        end
        ATC_MODE_PHASE: begin
          // Dual slope: turn at max and bottom
          if (count_down) begin
            next_count = at_bottom ? count_value + 8'h01 : count_value - 8'h01;
            next_down  = ~at_bottom;
            ovf_set    = at_bottom;                                  // [RQ8]
          end else begin
            next_count = at_max ? count_value - 8'h01 : count_value + 8'h01;
            next_down  = at_max;
            buf_load   = at_max;                                     // [RQ11]
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Waveform generator
  // Output mode acts from the edge it is written on, so a force strobe that
  // arrives with a new mode applies that new mode, not the stale one
  atc_ctrl_t  ctrl_in;
  logic [1:0] com;
  assign ctrl_in = atc_ctrl_t'(hwdata[7:0]);
  assign com     = wr_ctrl ? ctrl_in.compare_output_mode
                           : timer_control_register.compare_output_mode; // [RQ17]
  logic next_out;
  always_comb begin
    next_out = compare_output;
    if (com != 2'h0) begin                                           // [RQ23]
      if (!pwm_mode) begin
        if (hit | force_now) begin                                   // [RQ15]
          unique case (com)
            2'h1:    next_out = ~compare_output;
            2'h2:    next_out = 1'b0;
            default: next_out = 1'b1;
          endcase
        end
      end else if (mode == ATC_MODE_FAST) begin
        if (hit) begin
          next_out = com[0];
        end else if (timer_tick & at_max) begin
          next_out = ~com[0];                                        // Opposite of the match level at bottom
        end
      end else if (hit) begin
        next_out = com[0] ^ count_down;                              // Phase correct
      end
    end
  end

  // ==========================================================================
  // Flag updates: set beats clear
  wire ovf_clr = (wr_flags & hwdata[ATC_FLD_OVF]) | ack_overflow;
  wire cmp_clr = (wr_flags & hwdata[ATC_FLD_CMP]) | ack_compare;
  atc_pair_t next_flags;
  assign next_flags.overflow = ovf_set | (timer_flag_register.overflow & ~ovf_clr); // [RQ24]
  assign next_flags.compare  = hit | (timer_flag_register.compare & ~cmp_clr);      // [RQ10]

  // Read mux
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (rd_addr)
      ATC_OFS_CONTROL: rd_word[6:0] = timer_control_register[6:0];
      ATC_OFS_COUNT:   rd_word[7:0] = count_value;                   // [RQ5]
      ATC_OFS_COMPARE: rd_word[7:0] = pwm_mode ? compare_buffer : compare_value; // [RQ12]
      ATC_OFS_FLAGS:   rd_word[1:0] = timer_flag_register;
      ATC_OFS_MASK:    rd_word[1:0] = timer_mask_register;
      ATC_OFS_ASYNC:   rd_word[0]   = async_clock_select;
      default:         rd_word      = 32'h0000_0000;
    endcase
  end

  // ==========================================================================
  // Bus slave sequencing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state <= ATC_BUS_IDLE;
      wr_pend   <= 1'b0;
      wr_addr   <= ATC_RST_BYTE;
      rd_addr   <= ATC_RST_BYTE;
      hrdata    <= 32'h0000_0000;
    end else begin
      wr_pend <= addr_take & hwrite;
      if (addr_take) begin
        wr_addr <= haddr[7:0];
        rd_addr <= haddr[7:0];
      end
      unique case (bus_state)
        ATC_BUS_RWAIT: begin
          bus_state <= ATC_BUS_RDONE;
          hrdata    <= rd_word;
        end
        default: bus_state <= (addr_take & ~hwrite) ? ATC_BUS_RWAIT : ATC_BUS_IDLE;
      endcase
    end
  end

  // Control and mask registers; force bit is a strobe, never stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_control_register <= ATC_RST_CTRL;
      timer_mask_register    <= '0;
      async_clock_select     <= 1'b0;
    end else begin
      if (wr_ctrl) timer_control_register <= {1'b0, hwdata[6:0]};
      if (wr_mask) timer_mask_register    <= hwdata[1:0];
      if (wr_async) async_clock_select    <= hwdata[ATC_FLD_ASYNC];
    end
  end

  // Prescaler and crystal edge history
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc        <= ATC_PRESC_ZERO;
      crystal_prev <= 1'b0;
    end else begin
      crystal_prev <= crystal_pin_in;
      if (csel == 3'h0)  presc <= ATC_PRESC_ZERO;
      else if (src_tick) presc <= presc + 10'h001;
    end
  end

  // Counter, direction, block; CPU write wins over any count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_value <= ATC_RST_BYTE;
      count_down  <= 1'b0;
      block_match <= 1'b0;
    end else begin
      count_value <= wr_count ? hwdata[7:0] : next_count;            // [RQ6]
      count_down  <= next_down;
      if (wr_count)        block_match <= 1'b1;                      // [RQ14]
      else if (timer_tick) block_match <= 1'b0;
    end
  end

  // Compare value with double buffer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_value  <= ATC_RST_BYTE;
      compare_buffer <= ATC_RST_BYTE;
    end else begin
      if (wr_cmp) compare_buffer <= hwdata[7:0];
      if (wr_cmp & ~pwm_mode)  compare_value <= hwdata[7:0];         // [RQ12]
      else if (pwm_mode & buf_load) compare_value <= compare_buffer; // [RQ11]
    end
  end

  // Flags and output state; output survives mode changes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_flag_register <= '0;
      compare_output      <= 1'b0;
    end else begin
      timer_flag_register <= next_flags;
      compare_output      <= next_out;                               // [RQ16]
    end
  end

  // Masked requests and pin override
  assign irq_overflow = timer_flag_register.overflow & timer_mask_register.overflow; // [RQ20]
  assign irq_compare  = timer_flag_register.compare & timer_mask_register.compare;   // [RQ10]
  assign compare_output_override = (timer_control_register.compare_output_mode != 2'h0);

  // ==========================================================================
  // Assertions
  AST_WRITE_WINS: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ6]
    wr_count |=> (count_value == $past(hwdata[7:0]) && block_match))
    else $error("counter write lost");
  AST_STOPPED: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ4]
    (csel == 3'h0 && !wr_count) |=> $stable(count_value))
    else $error("stopped counter moved");
  AST_CMP_FLAG: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ9]
    (timer_tick && match && !block_match) |=> timer_flag_register.compare)
    else $error("match did not set flag");
  AST_BLOCK: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ14]
    (wr_count ##1 (timer_tick && !wr_count && !timer_flag_register.compare))
      |=> !timer_flag_register.compare)
    else $error("blocked match set flag");
  AST_NORMAL_WRAP: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ21]
    (timer_tick && mode == ATC_MODE_NORMAL && at_max && !wr_count)
      |=> (count_value == 8'h00 && timer_flag_register.overflow))
    else $error("normal wrap wrong");
  AST_CTC_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ22]
    (timer_tick && mode == ATC_MODE_CTC && match && !wr_count) |=> count_value == 8'h00)
    else $error("clear on match missed");
  AST_FORCE_NOFLAG: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ13]
    (force_now && !timer_tick && !timer_flag_register.compare && !wr_count)
      |=> (!timer_flag_register.compare && $stable(count_value)))
    else $error("force touched flag or counter");
  AST_SET_WINS: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ24]
    (hit && cmp_clr) |=> timer_flag_register.compare)
    else $error("clear beat set");
  AST_COM_ZERO: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ23]
    (com == 2'h0) |=> $stable(compare_output))
    else $error("output moved with mode zero");
  AST_IRQ: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ10]
    (cmp_clr && !hit) |=> !irq_compare)
    else $error("cleared compare flag still requests");
  AST_BUFFER: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ11]
    (pwm_mode && !buf_load) |=> $stable(compare_value))
    else $error("active compare changed mid cycle");

  // ==========================================================================
  // Counting sequences, flags and forced output
  AST_FAST_OVF: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ8]
    (timer_tick && mode == ATC_MODE_FAST && at_max) |=> timer_flag_register.overflow)
    else $error("fast wrap missed overflow");
  AST_PHASE_TURN: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ7]
    (timer_tick && mode == ATC_MODE_PHASE && at_max && !count_down && !wr_count)
      |=> (count_value == ATC_MAX - 8'h01 && count_down))
    else $error("dual slope did not turn at max");
  AST_PHASE_BOTTOM: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ8]
    (timer_tick && mode == ATC_MODE_PHASE && at_bottom && count_down)
      |=> (timer_flag_register.overflow && !count_down))
    else $error("dual slope bottom turn wrong");
  AST_FORCE_SET: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ13]
    (force_now && com == 2'h3) |=> compare_output)
    else $error("forced set did not reach output");
  AST_FORCE_CLR: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ13]
    (force_now && com == 2'h2) |=> !compare_output)
    else $error("forced clear did not reach output");
  AST_FLAG_HOLD: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ10]
    (!hit && !cmp_clr) |=> $stable(timer_flag_register.compare))
    else $error("compare flag moved with no cause");
  AST_BLOCK_ONCE: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ14]
    (timer_tick && !wr_count) |=> !block_match)
    else $error("match block outlived one tick");
  AST_CTC_STEP: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ7]
    (timer_tick && mode == ATC_MODE_CTC && !at_top && !wr_count)
      |=> count_value == $past(count_value) + 8'h01)
    else $error("clear-on-match count did not step");
  AST_BUF_BYPASS: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ12]
    (wr_cmp && !pwm_mode) |=> compare_value == $past(hwdata[7:0]))
    else $error("direct compare write lost");

endmodule : atc_timer

/* File: verif/atc_timer_test.sv */
// Self-checking bench for the 8-bit timer with one compare unit.
// Assumes atc_pkg offsets, one AHB-Lite slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
module atc_timer_test;
  import atc_pkg::*;

  // ==========================================================================
  // Signals
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        crystal_pin_in;
  logic        ack_overflow;
  logic        ack_compare;
  logic        irq_overflow;
  logic        irq_compare;
  logic        compare_output;
  logic        compare_output_override;
  int unsigned num_errors;
  int unsigned n_compared;
  int unsigned cycles;

  atc_timer #(.PRESC_BITS(10)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .crystal_pin_in(crystal_pin_in), .ack_overflow(ack_overflow),
    .ack_compare(ack_compare), .irq_overflow(irq_overflow), .irq_compare(irq_compare),
    .compare_output(compare_output), .compare_output_override(compare_output_override)
  );

  // ==========================================================================
  // Clock and hang guard
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // Ceiling well above the several hundred cycles the sequence needs
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  // ==========================================================================
  // Helpers
  task automatic wrap_up();
    $display("errors=%0d compared=%0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask : check

  // Samples ready before the edge, so flop updates at the edge cannot race
  task automatic wait_ready(output logic [31:0] q);
    logic r;
    int   k;
    r = 1'b0;
    k = 0;
    while (r !== 1'b1) begin
      @(negedge hclk);
      r = hreadyout;
      q = hrdata;
      k++;
      if (k > 16) begin
        num_errors++;
        r = 1'b1;
      end
      @(posedge hclk);
    end
  endtask : wait_ready

  // One single word transfer: address phase, then data phase
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready(q);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h00000000;
    wait_ready(q);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h00000000, q);
    check(q, e);
  endtask : rdc

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc

  // Expected output state after a match, by output mode (non-PWM)
  function automatic logic nxt_out(input logic [1:0] om, input logic cur);
    case (om)
      2'h1: return ~cur;
      2'h2: return 1'b0;
      2'h3: return 1'b1;
      default: return cur;
    endcase
  endfunction : nxt_out

  // ==========================================================================
  // Main sequence
  initial begin
    logic [31:0] q;
    logic [7:0]  v;
    logic [7:0]  c;
    logic [1:0]  oms [7];
    logic        eo;
    int          k;
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = '0; crystal_pin_in = 1'b0; ack_overflow = 1'b0;
    ack_compare = 1'b0; num_errors = 0; n_compared = 0; cycles = 0;
    oms = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h0, 2'h3, 2'h0};
    void'($urandom(23779));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, unmapped place reads zero and ignores writes
    for (k = 0; k < 7; k++) rdc(8'(4 * k), 32'h0);
    wr(8'h18, 32'h5a);
    rdc(8'h18, 32'h0);
    // Stopped counter keeps a written value
    v = 8'($urandom);
    wr(ATC_OFS_COUNT, {24'h0, v});
    cyc(20);
    rdc(ATC_OFS_COUNT, {24'h0, v});
    // Overflow at wrap, masked request, ack and write-one clear
    wr(ATC_OFS_MASK, 32'h1);
    wr(ATC_OFS_COUNT, 32'hfd);
    wr(ATC_OFS_CONTROL, 32'h01);
    for (k = 0; k < 20 && irq_overflow !== 1'b1; k++) @(negedge hclk);
    check({31'h0, irq_overflow}, 32'h1);
    wr(ATC_OFS_CONTROL, 32'h00);
    xfer(1'b0, ATC_OFS_FLAGS, 32'h0, q);
    check(q & 32'h1, 32'h1);
    @(posedge hclk) ack_overflow <= 1'b1;
    @(posedge hclk) ack_overflow <= 1'b0;
    @(negedge hclk) check({31'h0, irq_overflow}, 32'h0);
    wr(ATC_OFS_FLAGS, 32'h3);
    rdc(ATC_OFS_FLAGS, 32'h0);
    // Counter write equal to compare loses that match
    c = 8'h20 + 8'($urandom % 192);
    wr(ATC_OFS_MASK, 32'h3);
    wr(ATC_OFS_COMPARE, {24'h0, c});
    wr(ATC_OFS_COUNT, {24'h0, c});
    wr(ATC_OFS_CONTROL, 32'h01);
    wr(ATC_OFS_CONTROL, 32'h00);
    rdc(ATC_OFS_FLAGS, 32'h0);
    // Match sets the flag on the following tick
    wr(ATC_OFS_COUNT, {24'h0, c - 8'h3});
    wr(ATC_OFS_CONTROL, 32'h01);
    // Interrupt ack lands on the very edge of the match: the set must win
    cyc(3);
    ack_compare <= 1'b1;
    @(posedge hclk) ack_compare <= 1'b0;
    for (k = 0; k < 20 && irq_compare !== 1'b1; k++) @(negedge hclk);
    check({31'h0, irq_compare}, 32'h1);
    wr(ATC_OFS_CONTROL, 32'h00);
    rdc(ATC_OFS_FLAGS, 32'h2);
    wr(ATC_OFS_MASK, 32'h1);
    @(negedge hclk) check({31'h0, irq_compare}, 32'h0);
    @(posedge hclk) ack_compare <= 1'b1;
    @(posedge hclk) ack_compare <= 1'b0;
    rdc(ATC_OFS_FLAGS, 32'h0);
    // Clear-on-match keeps the count at or below the compare value
    c = 8'h3 + 8'($urandom % 8);
    wr(ATC_OFS_COMPARE, {24'h0, c});
    wr(ATC_OFS_COUNT, 32'h0);
    wr(ATC_OFS_CONTROL, 32'h11);
    cyc(100);
    wr(ATC_OFS_CONTROL, 32'h10);
    xfer(1'b0, ATC_OFS_COUNT, 32'h0, q);
    check({31'h0, q <= {24'h0, c}}, 32'h1);
    // Write to a running counter wins over the count
    v = 8'h10 + 8'($urandom % 200);
    wr(ATC_OFS_CONTROL, 32'h01);
    wr(ATC_OFS_COUNT, {24'h0, v});
    wr(ATC_OFS_CONTROL, 32'h00);
    xfer(1'b0, ATC_OFS_COUNT, 32'h0, q);
    check({31'h0, (q[7:0] - v) <= 8'h4}, 32'h1);
    // Force strobe through every output mode, counter stopped
    wr(ATC_OFS_FLAGS, 32'h3);
    wr(ATC_OFS_COUNT, 32'h33);
    eo = 1'b0;
    for (k = 0; k < 7; k++) begin
      wr(ATC_OFS_CONTROL, {24'h0, 1'b1, oms[k], 5'h00});
      eo = nxt_out(oms[k], eo);
      rdc(ATC_OFS_FLAGS, 32'h0);
      @(negedge hclk) check({31'h0, compare_output}, {31'h0, eo});
      check({31'h0, compare_output_override}, {31'h0, oms[k] != 2'h0});
    end
    rdc(ATC_OFS_COUNT, 32'h33);
    wr(ATC_OFS_CONTROL, 32'h18);
    @(negedge hclk) check({31'h0, compare_output}, {31'h0, eo});
    // Double buffer: PWM writes reach the buffer, active copy loads at wrap
    wr(ATC_OFS_CONTROL, 32'h00);
    wr(ATC_OFS_COMPARE, 32'h11);
    wr(ATC_OFS_CONTROL, 32'h18);
    v = 8'h40 + 8'($urandom % 64);
    wr(ATC_OFS_COMPARE, {24'h0, v});
    rdc(ATC_OFS_COMPARE, {24'h0, v});
    wr(ATC_OFS_CONTROL, 32'h00);
    rdc(ATC_OFS_COMPARE, 32'h11);
    wr(ATC_OFS_CONTROL, 32'h18);
    wr(ATC_OFS_COUNT, 32'hfc);
    wr(ATC_OFS_CONTROL, 32'h79);
    cyc(10);
    @(negedge hclk) check({31'h0, compare_output}, 32'h0);
    wr(ATC_OFS_CONTROL, 32'h00);
    rdc(ATC_OFS_COMPARE, {24'h0, v});
    // Dual slope: no overflow at the max turn, overflow at the bottom turn
    wr(ATC_OFS_FLAGS, 32'h3);
    wr(ATC_OFS_COUNT, 32'hfd);
    wr(ATC_OFS_CONTROL, 32'h09);
    cyc(8);
    rdc(ATC_OFS_FLAGS, 32'h0);
    wr(ATC_OFS_COUNT, 32'h03);
    for (k = 0; k < 20 && irq_overflow !== 1'b1; k++) @(negedge hclk);
    check({31'h0, irq_overflow}, 32'h1);
    wr(ATC_OFS_CONTROL, 32'h08);
    xfer(1'b0, ATC_OFS_COUNT, 32'h0, q);
    check({31'h0, q < 32'h20}, 32'h1);
    // Crystal source: count only its rising edges
    c = 8'h5 + 8'($urandom % 16);
    wr(ATC_OFS_COUNT, 32'h0);
    wr(ATC_OFS_ASYNC, 32'h1);
    rdc(ATC_OFS_ASYNC, 32'h1);
    wr(ATC_OFS_CONTROL, 32'h01);
    cyc(10);
    repeat (c) begin
      @(posedge hclk) crystal_pin_in <= 1'b1;
      cyc(3);
      @(posedge hclk) crystal_pin_in <= 1'b0;
      cyc(3);
    end
    wr(ATC_OFS_CONTROL, 32'h00);
    rdc(ATC_OFS_COUNT, {24'h0, c});
    check({31'h0, hresp}, 32'h0);
    wrap_up();
  end

endmodule : atc_timer_test
